// >>> hdl/serial_audio_pkg.sv
package serial_audio_pkg;
   // Register map, byte offsets on the device register port
   localparam logic [7:0] WORD_FORMAT_CFG_ADDR = 8'h35;
   localparam logic [7:0] FRAME_CLOCK_CFG_ADDR = 8'h36;
   localparam logic [7:0] RX_STATUS_ADDR = 8'h37;
   localparam logic [7:0] WORD_FORMAT_CFG_RESET = 8'h01;
   localparam logic [7:0] FRAME_CLOCK_CFG_RESET = 8'h01;

   // Field positions inside the two configuration registers
   localparam int FMT_LSB = 0;
   localparam int FMT_MSB = 2;
   localparam int CAPTURE_RISE_BIT = 0;
   localparam int WORD_SELECT_POLARITY_BIT = 1;
   localparam int LSB_FIRST_BIT = 2;
   localparam int FRAME_LSB = 3;
   localparam int FRAME_MSB = 4;
   localparam int RIGHT_FIRST_BIT = 5;
   // Status register bits
   localparam int STAT_OVERRUN_BIT = 0;
   localparam int STAT_PENDING_BIT = 1;

   // Word format codes
   localparam logic [2:0] FMT_I2S = 3'h0;
   localparam logic [2:0] FMT_LEFT_JUST = 3'h1;
   localparam logic [2:0] FMT_RJ16 = 3'h4;
   localparam logic [2:0] FMT_RJ20 = 3'h5;
   localparam logic [2:0] FMT_RJ18 = 3'h6;
   localparam logic [2:0] FMT_RJ24 = 3'h7;

   // Frame size codes and bit clocks per half word select period
   localparam logic [1:0] FRAME_64 = 2'h0;
   localparam logic [1:0] FRAME_48 = 2'h1;
   localparam logic [1:0] FRAME_32 = 2'h2;
   localparam logic [5:0] HALF_64 = 6'h20;
   localparam logic [5:0] HALF_48 = 6'h18;
   localparam logic [5:0] HALF_32 = 6'h10;

   // Word lengths
   localparam logic [5:0] LEN_16 = 6'h10;
   localparam logic [5:0] LEN_18 = 6'h12;
   localparam logic [5:0] LEN_20 = 6'h14;
   localparam logic [5:0] LEN_24 = 6'h18;
   localparam int SAMPLE_W = 24;

   // Received stereo pair, MSB aligned
   typedef struct packed {
      logic [SAMPLE_W-1:0] left;
      logic [SAMPLE_W-1:0] right;
   } pcm_pair_t;

   // Bit window of a word inside its slot
   typedef struct packed {
      logic [5:0] start;
      logic [5:0] len;
   } slot_win_t;
endpackage

// >>> hdl/serial_audio_rx.sv
`timescale 1ns/1ns
// Overview of operation
// - Format code selects I2S, left or right justified
// - Order bit picks left or right first
// - Frame code sets 64, 48 or 32 clocks
// - Order bit picks MSB or LSB first
// - Polarity bit sets word select level, first word
// - Edge bit clear: sample on falling edge
// - Edge bit set: sample on rising edge
module serial_audio_rx
   import serial_audio_pkg::*;
(
   input wire logic core_clk, // System clock, 250 MHz
   input wire logic rst, // Synchronous reset, active high
   input wire logic regWrEn, // Register write strobe
   input wire logic [7:0] regAddr, // Register address
   input wire logic [7:0] regWrData, // Register write data
   output logic [7:0] regRdData, // Registered read data for regAddr
   input wire logic serialBitClk, // Bit clock from the audio source
   input wire logic wordSelect, // Word select from the source
   input wire logic serial_audio_input, // Serial data from the source
   output pcm_pair_t pcmPair, // Received stereo pair
   output logic pcmValid, // Pair held in pcmPair
   input wire logic pcmReady, // Consumer takes pcmPair
   output logic overrun // Pulse: a pair was dropped, buffer full
);

   // Half frame length for a frame code; unused code acts as 64
   function automatic logic [5:0] half_size(input logic [1:0] code);
      case (code)
         FRAME_48: half_size = HALF_48;
         FRAME_32: half_size = HALF_32;
         default: half_size = HALF_64;
      endcase
   endfunction

   // Bit window of the word within a slot of the given length
   function automatic slot_win_t slot_window(input logic [2:0] fmt, input logic [5:0] half);
      slot_win_t w;
      logic [5:0] len;
      len = LEN_24;
      w.start = 6'h00;
      w.len = LEN_24;
      case (fmt)
         FMT_LEFT_JUST: begin
            w.len = (half < LEN_24) ? half : LEN_24;
         end
         FMT_RJ16, FMT_RJ18, FMT_RJ20, FMT_RJ24: begin
            if (fmt == FMT_RJ16) len = LEN_16;
            else if (fmt == FMT_RJ18) len = LEN_18;
            else if (fmt == FMT_RJ20) len = LEN_20;
            else len = LEN_24;
            // A word longer than its slot loses its low bits
            if (len > half) len = half;
            w.start = half - len;
            w.len = len;
         end
         default: begin // Standard I2S, one clock of delay
            w.start = 6'h01;
            w.len = ((half - 6'h01) < LEN_24) ? (half - 6'h01) : LEN_24;
         end
      endcase
      return w;
   endfunction

   // ---------------- Core domain: registers ----------------
   logic [7:0] wordFormatCfg; // Word format register
   logic [7:0] frameClockCfg; // Frame and clock register
   logic overrunSticky; // Seen a dropped pair
   logic push; // New pair arrived from the link
   logic spareValid; // Second buffer entry occupied
   logic overrunEvt; // Pair dropped this cycle

   // Configuration writes
   always_ff @(posedge core_clk) begin
      if (rst) begin
         wordFormatCfg <= WORD_FORMAT_CFG_RESET;
         frameClockCfg <= FRAME_CLOCK_CFG_RESET;
      end else if (regWrEn) begin
         if (regAddr == WORD_FORMAT_CFG_ADDR) wordFormatCfg <= regWrData;
         if (regAddr == FRAME_CLOCK_CFG_ADDR) frameClockCfg <= regWrData;
      end
   end

   // Sticky overrun; a new drop wins over a write-one clear
   always_ff @(posedge core_clk) begin
      if (rst) begin
         overrunSticky <= 1'b0;
      end else if (overrunEvt) begin
         overrunSticky <= 1'b1;
      end else if (regWrEn && regAddr == RX_STATUS_ADDR && regWrData[STAT_OVERRUN_BIT]) begin
         overrunSticky <= 1'b0;
      end
   end

   // Read mux, registered; unmapped addresses read zero
   always_ff @(posedge core_clk) begin
      if (rst) begin
         regRdData <= 8'h00;
      end else begin
         case (regAddr)
            WORD_FORMAT_CFG_ADDR: regRdData <= wordFormatCfg;
            FRAME_CLOCK_CFG_ADDR: regRdData <= frameClockCfg;
            RX_STATUS_ADDR: begin
               regRdData <= 8'h00;
               regRdData[STAT_OVERRUN_BIT] <= overrunSticky;
               regRdData[STAT_PENDING_BIT] <= pcmValid;
            end
            default: regRdData <= 8'h00;
         endcase
      end
   end

   // ---------------- Link domain ----------------
   logic [15:0] cfgMeta; // First stage, config crossing
   logic [15:0] cfgLink; // Config in link domain
   logic rstMeta; // First stage, reset crossing
   logic rstLink; // Reset in link domain
   logic sdFall; // Data caught on falling edge
   logic wsFall; // Word select caught on falling edge
   logic sdBit; // Data bit for this clock
   logic wsBit; // Word select for this clock
   logic wsPrev; // Word select of previous clock
   logic [5:0] bitCnt; // Position in current slot
   logic [SAMPLE_W-1:0] acc; // Word being assembled
   logic [SAMPLE_W-1:0] firstWord; // First word of the pair
   logic firstSeen; // First word of this pair captured
   pcm_pair_t pairHold; // Last full pair, stable for a frame
   logic pairToggle; // Flips once per full pair

   // Config and reset cross as quasi-static levels
   always_ff @(posedge serialBitClk) begin
      cfgMeta <= {frameClockCfg, wordFormatCfg};
      cfgLink <= cfgMeta;
      rstMeta <= rst;
      rstLink <= rstMeta;
   end

   logic [2:0] fmt; // Word format code
   logic [1:0] frameCode; // Frame size code
   logic lsbFirst; // LSB travels first
   logic wsPolHigh; // First word while word select high
   logic rightFirst; // Right word comes first
   logic captureRise; // Sample on rising edge
   assign fmt = cfgLink[FMT_MSB:FMT_LSB];
   assign frameCode = cfgLink[8+FRAME_MSB:8+FRAME_LSB];
   assign lsbFirst = cfgLink[8+LSB_FIRST_BIT];
   assign wsPolHigh = cfgLink[8+WORD_SELECT_POLARITY_BIT];
   assign rightFirst = cfgLink[8+RIGHT_FIRST_BIT];
   assign captureRise = cfgLink[8+CAPTURE_RISE_BIT];

   // Falling edge capture; used at the next rising edge
   always_ff @(negedge serialBitClk) begin
      sdFall <= serial_audio_input;
      wsFall <= wordSelect;
   end

   // Pick the capture edge the source is not changing on
   assign sdBit = captureRise ? serial_audio_input : sdFall;
   assign wsBit = captureRise ? wordSelect : wsFall;

   logic newSlot; // Word select changed, slot starts
   logic [5:0] idx; // Index of this bit in slot
   slot_win_t win; // Word window for current config
   logic take; // This bit belongs to the word
   logic lastBit; // Final bit of the word
   logic isFirst; // Slot carries the first word
   logic [SAMPLE_W-1:0] next_acc; // Accumulator after this bit
   logic [SAMPLE_W-1:0] aligned; // Finished word, MSB aligned
   logic [4:0] padShift; // Unused low bits of the word

   assign newSlot = wsBit != wsPrev;
   assign idx = newSlot ? 6'h00 : bitCnt;
   assign win = slot_window(fmt, half_size(frameCode));
   assign take = (idx >= win.start) && (idx < win.start + win.len);
   assign lastBit = take && (idx == win.start + win.len - 6'h01);
   assign isFirst = wsBit == wsPolHigh;
   assign padShift = 5'(6'(SAMPLE_W) - win.len);

   // Shift in one bit in the configured order
   always_comb begin
      next_acc = (idx == win.start) ? '0 : acc;
      if (lsbFirst) begin
         next_acc = {sdBit, next_acc[SAMPLE_W-1:1]};
      end else begin
         next_acc = {next_acc[SAMPLE_W-2:0], sdBit};
      end
      // LSB first already lands aligned; MSB first needs a left shift
      aligned = lsbFirst ? next_acc : (next_acc << padShift);
   end

   // Slot bit counter and word select history
   always_ff @(posedge serialBitClk) begin
      if (rstLink) begin
         wsPrev <= 1'b0;
         bitCnt <= 6'h00;
      end else begin
         wsPrev <= wsBit;
         // Saturate on idx, so a long idle never wraps back into the word window
         bitCnt <= (idx == 6'h3F) ? idx : idx + 6'h01;
      end
   end

   // Word assembly and pair hand-off
   always_ff @(posedge serialBitClk) begin
      if (rstLink) begin
         acc <= '0;
         firstWord <= '0;
         firstSeen <= 1'b0;
         pairHold <= '0;
         pairToggle <= 1'b0;
      end else if (take) begin
         acc <= next_acc;
         if (lastBit && isFirst) begin
            firstWord <= aligned;
            firstSeen <= 1'b1;
         end else if (lastBit && firstSeen) begin
            // Second word completes the pair
            firstSeen <= 1'b0;
            pairToggle <= ~pairToggle;
            if (rightFirst) begin
               pairHold.left <= aligned;
               pairHold.right <= firstWord;
            end else begin
               pairHold.left <= firstWord;
               pairHold.right <= aligned;
            end
         end
      end
   end

   // ---------------- Core domain: pair intake ----------------
   logic tgMeta; // First stage, pair toggle
   logic tgSync; // Synchronised pair toggle
   logic tgPrev; // Previous synchronised toggle
   logic pop; // Consumer takes head
   pcm_pair_t spare; // Second buffer entry

   // Toggle crossing; pairHold is stable long before the toggle lands
   always_ff @(posedge core_clk) begin
      if (rst) begin
         tgMeta <= 1'b0;
         tgSync <= 1'b0;
         tgPrev <= 1'b0;
      end else begin
         tgMeta <= pairToggle;
         tgSync <= tgMeta;
         tgPrev <= tgSync;
      end
   end

   assign push = tgSync ^ tgPrev;
   assign pop = pcmValid && pcmReady;
   // The source cannot be stalled, so a full buffer drops and flags
   assign overrunEvt = push && pcmValid && !pop && spareValid;

   // Two-entry buffer: head drives the outputs, spare absorbs a stall
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pcmPair <= '0;
         pcmValid <= 1'b0;
         spare <= '0;
         spareValid <= 1'b0;
      end else if (pop || !pcmValid) begin
         if (spareValid) begin
            pcmPair <= spare;
            pcmValid <= 1'b1;
            if (push) spare <= pairHold;
            spareValid <= push;
         end else begin
            if (push) pcmPair <= pairHold;
            pcmValid <= push;
         end
      end else if (push && !spareValid) begin
         spare <= pairHold;
         spareValid <= 1'b1;
      end
   end

   // Overrun pulse, registered
   always_ff @(posedge core_clk) begin
      if (rst) begin
         overrun <= 1'b0;
      end else begin
         overrun <= overrunEvt;
      end
   end

endmodule

// >>> test/audio_source_model.sv
`timescale 1ns/1ns
// Behavioural audio source on the three-wire link
module audio_source_model (
   output logic sck, // Bit clock, still between frames
   output logic ws, // Word select
   output logic sd // Serial data
);
   initial begin
      sck = 1'b0;
      ws = 1'b0;
      sd = 1'b0;
   end

   // One 80 ns bit period; data moves on the edge the receiver ignores
   task automatic tick(input logic rise, input logic w, input logic d);
      sck = !rise;
      ws = w;
      sd = d;
      #40 sck = rise;
      #40 sck = 1'b0;
   endtask

   // Lead-in at second-slot level, two slots, tail so the last bit lands
   task automatic send(input logic [47:0] pair, input int half, input int start, input int len,
      input logic [7:0] cfg);
      int i;
      int b;
      logic [23:0] w;
      repeat (3) tick(cfg[0], ~cfg[1], ~sd);
      for (i = 0; i < 2 * half; i++) begin
         w = (i < half) ? pair[47:24] : pair[23:0];
         b = i % half - start;
         // Bits outside the word toggle, so stale data never looks valid
         if (b >= 0 && b < len) tick(cfg[0], cfg[1] ^ (i >= half), cfg[2] ? w[24 - len + b] : w[23 - b]);
         else tick(cfg[0], cfg[1] ^ (i >= half), ~sd);
      end
      repeat (2) tick(cfg[0], ~cfg[1], ~sd);
   endtask
endmodule

// >>> test/serial_audio_rx_assertions.sv
`timescale 1ns/1ns
// Watches register port and pair output of the receiver
module serial_audio_rx_assertions
   import serial_audio_pkg::*;
(
   input wire logic core_clk, // System clock
   input wire logic rst, // Sync reset
   input wire logic regWrEn, // Write strobe
   input wire logic [7:0] regAddr, // Address
   input wire logic [7:0] regWrData, // Write data
   input wire logic [7:0] regRdData, // Read data
   input wire pcm_pair_t pcmPair, // Pair out
   input wire logic pcmValid, // Pair pending
   input wire logic pcmReady, // Pair taken
   input wire logic overrun // Drop pulse
);
   // One domain only, so clock and reset are shared
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (rst);

   fmt_readback_a: assert property ((regWrEn && regAddr == 8'h35) ##1 (!regWrEn && regAddr == 8'h35)
      |=> regRdData == $past(regWrData, 2)) else $error("format register readback wrong");
   rj20_code_a: assert property ((regWrEn && regAddr == 8'h35 && regWrData[2:0] == 3'h5) ##1 !regWrEn
      |=> regRdData[2:0] == 3'h5) else $error("code 101 not kept");
   frame_readback_a: assert property ((regWrEn && regAddr == 8'h36) ##1 (!regWrEn && regAddr == 8'h36)
      |=> regRdData == $past(regWrData, 2)) else $error("frame register readback wrong");
   pair_stable_a: assert property (pcmValid && !pcmReady |=> pcmValid && $stable(pcmPair))
      else $error("pending pair changed");
   status_pending_a: assert property (regAddr == 8'h37 |=> regRdData[7:1] == {6'h00, $past(pcmValid)})
      else $error("status pending bit wrong");
   unmapped_zero_a: assert property ((regAddr < 8'h35 || regAddr > 8'h37) |=> regRdData == 8'h00)
      else $error("unmapped read not zero");
   overrun_pulse_a: assert property (overrun |=> !overrun)
      else $error("overrun longer than a cycle");
   overrun_full_a: assert property (overrun |-> pcmValid && $past(pcmValid))
      else $error("overrun without full buffer");
endmodule

bind serial_audio_rx serial_audio_rx_assertions chk (.core_clk(core_clk), .rst(rst), .regWrEn(regWrEn),
   .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .pcmPair(pcmPair),
   .pcmValid(pcmValid), .pcmReady(pcmReady), .overrun(overrun));

// >>> test/tb_top.sv
`timescale 1ns/1ns
// Self-checking bench for the serial audio receiver
module tb_top
   import serial_audio_pkg::*;
;
   logic core_clk; // 250 MHz clock
   logic rst; // Sync reset
   logic regWrEn; // Write strobe
   logic [7:0] regAddr; // Address
   logic [7:0] regWrData; // Write data
   logic [7:0] regRdData; // Read data
   logic sck; // Link bit clock
   logic ws; // Word select
   logic sd; // Serial data
   pcm_pair_t pcmPair; // Received pair
   logic pcmValid; // Pair pending
   logic pcmReady; // Consumer ready
   logic overrun; // Drop pulse
   int mismatches = 0; // Failed compares
   int cmp_count = 0; // All compares
   int cycles = 0; // Hang guard
   int overrunPulses = 0; // Drop pulses seen

   serial_audio_rx dut (.core_clk(core_clk), .rst(rst), .regWrEn(regWrEn), .regAddr(regAddr),
      .regWrData(regWrData), .regRdData(regRdData), .serialBitClk(sck), .wordSelect(ws),
      .serial_audio_input(sd), .pcmPair(pcmPair), .pcmValid(pcmValid), .pcmReady(pcmReady), .overrun(overrun));
   audio_source_model src (.sck(sck), .ws(ws), .sd(sd));

   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   // Whole run needs about 23k cycles
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 60000) begin
         mismatches++;
         test_done();
      end
   end

   // Count drop pulses; the value before this edge's update is seen
   always @(posedge core_clk) begin
      if (overrun === 1'b1) overrunPulses++;
   end

   task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic test_done();
      $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // One-cycle write strobe, address left standing
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk) #1;
      regAddr = a;
      regWrData = d;
      regWrEn = 1'b1;
      @(posedge core_clk) #1;
      regWrEn = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge core_clk) #1;
      regAddr = a;
      repeat (2) @(posedge core_clk) #1;
      check("register", regRdData, e);
   endtask

   // Bounded wait for a pair, compare, then take it
   task automatic get(input logic [23:0] l, input logic [23:0] r);
      int n;
      for (n = 0; n < 100 && pcmValid !== 1'b1; n++) @(posedge core_clk) #1;
      check("valid", 48'(pcmValid), 48'h1);
      check("pair", pcmPair, {l, r});
      pcmReady = 1'b1;
      @(posedge core_clk) #1;
      pcmReady = 1'b0;
   endtask

   // Program format and frame, send a pair in link order, maybe collect it
   task automatic xfer(input logic [2:0] fmt, input logic [7:0] cfg, input logic [23:0] l,
      input logic [23:0] r, input bit take);
      int half;
      int start;
      int len;
      wr(8'h35, {5'h00, fmt});
      wr(8'h36, cfg);
      half = (cfg[4:3] == FRAME_48) ? 24 : (cfg[4:3] == FRAME_32) ? 16 : 32;
      len = (fmt == FMT_RJ16) ? 16 : (fmt == FMT_RJ18) ? 18 : (fmt == FMT_RJ20) ? 20 : 24;
      start = (fmt == FMT_I2S) ? 1 : 0;
      if (fmt[2] && len > half) len = half;
      if (!fmt[2] && half - start < 24) len = half - start;
      if (fmt[2]) start = half - len;
      src.send(cfg[5] ? {r, l} : {l, r}, half, start, len, cfg);
      if (take) get(l & ~(24'hFFFFFF >> len), r & ~(24'hFFFFFF >> len));
   endtask

   // Reset values, unmapped place, reserved bits kept
   task automatic t_regs();
      rd(8'h35, 8'h01);
      rd(8'h36, 8'h01);
      rd(8'h37, 8'h00);
      wr(8'h50, 8'hFF);
      rd(8'h50, 8'h00);
      wr(8'h35, 8'hF9);
      rd(8'h35, 8'hF9);
   endtask

   // Every word format, then short frames that clip the word
   task automatic t_formats();
      logic [2:0] fmts [6] = '{FMT_I2S, FMT_LEFT_JUST, FMT_RJ16, FMT_RJ18, FMT_RJ20, FMT_RJ24};
      foreach (fmts[k]) xfer(fmts[k], 8'h01, 24'hC35A96 ^ 24'(k), 24'h3CA5E1, 1'b1);
      xfer(FMT_I2S, 8'h11, 24'h9ABCDE, 24'h123457, 1'b1);
      xfer(FMT_RJ24, 8'h11, 24'hF0E1D2, 24'h0F1E2D, 1'b1);
   endtask

   // Each control bit of the frame register alone, then combined
   task automatic t_variants();
      logic [7:0] cfgs [7] = '{8'h00, 8'h03, 8'h05, 8'h09, 8'h11, 8'h21, 8'h26};
      foreach (cfgs[k]) xfer(FMT_LEFT_JUST, cfgs[k], 24'hB4D2E1 ^ 24'(k), 24'h5A1C39, 1'b1);
   endtask

   // Consumer stalls: two pairs held, third dropped, sticky flag cleared
   task automatic t_overrun();
      xfer(FMT_LEFT_JUST, 8'h01, 24'h111111, 24'h222222, 1'b0);
      xfer(FMT_LEFT_JUST, 8'h01, 24'h333333, 24'h444444, 1'b0);
      check("drop", 48'(overrunPulses), 48'h0);
      xfer(FMT_LEFT_JUST, 8'h01, 24'h555555, 24'h666666, 1'b0);
      check("drop", 48'(overrunPulses), 48'h1);
      rd(8'h37, 8'h03);
      get(24'h111111, 24'h222222);
      get(24'h333333, 24'h444444);
      check("pending", pcmValid, 48'h0);
      rd(8'h37, 8'h01);
      wr(8'h37, 8'h01);
      rd(8'h37, 8'h00);
   endtask

   // Link reset is synchronised on the bit clock, so it must run in reset
   initial begin
      rst = 1'b1;
      regWrEn = 1'b0;
      regAddr = 8'h00;
      regWrData = 8'h00;
      pcmReady = 1'b0;
      repeat (4) src.tick(1'b1, 1'b1, 1'b0);
      @(posedge core_clk) #1;
      rst = 1'b0;
      t_regs();
      t_formats();
      t_variants();
      t_overrun();
      test_done();
   end
endmodule
